// *** hw/bt_prescaler.sv ***
// Clock-enable prescaler for the basic timer.
`timescale 1ns/1ps
module bt_prescaler (
    input wire logic clock, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic ce, // Clock enable, freezes state when low.
    bt_tick_if.div p // Divider control and tick.
);

    logic [15:0] div_r; // Clocks since the last pulse.
    logic [15:0] div_nxt; // Next divider value.

    // A pulse is issued rather than a divided clock, so the whole block stays on one clock.
    assign p.tick = p.go && (div_r == p.presc);

    // Stopping or restarting returns the divider to zero so the first period is whole.
    assign div_nxt = (p.restart || !p.go || p.tick) ? 16'h0000 : div_r + 16'h0001;

    // The divider register itself.
    always_ff @(posedge clock)
    begin
        if (srst)
            div_r <= bt_pkg::RST_PRESC;
        else if (ce)
            div_r <= div_nxt;
    end

endmodule : bt_prescaler

// *** hw/bt_timer.sv ***
// Basic timer control block with its AHB-Lite register slave.
`timescale 1ns/1ps
module bt_timer #(
    parameter int CNT_W = bt_pkg::CNT_W_DEF // Counter width, 16 or 32.
) (
    input wire logic clock, // System clock, 25 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic ce, // Clock enable, freezes all state when low, except that a pending soft reset still takes effect.
    input wire logic hsel, // Slave select.
    input wire logic [7:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write when high.
    input wire logic [2:0] hsize, // Transfer size.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Bus ready.
    output logic [31:0] hrdata, // Read data.
    output logic hreadyout, // Slave ready.
    output logic hresp, // Response, always OKAY.
    output logic irq // Terminal event interrupt.
);

    // Implemented counter bits; the rest read as zero.
    localparam logic [31:0] CMASK = (CNT_W == 32) ? 32'hFFFF_FFFF : 32'h0000_FFFF;

    // Byte lanes touched by one access.
    function automatic logic [31:0] lane_mask(input logic [2:0] sz, input logic [1:0] a);
        logic [31:0] m;
        m = 32'hFFFF_FFFF;
        if (sz == bt_pkg::HSIZE_BYTE)
            m = 32'h0000_00FF << {a, 3'b000};
        else if (sz == bt_pkg::HSIZE_HALF)
            m = 32'h0000_FFFF << {a[1], 4'b0000};
        return m;
    endfunction : lane_mask

    bt_tick_if tk(); // Link to the prescaler.

    // Register state.
    logic [31:0] cnt_r; // Counter.
    logic [31:0] pre_r; // Preload.
    logic [31:0] snap_r; // Count snapshot for byte reads.
    logic stat_r; // Terminal event status.
    logic ie_r; // Interrupt enable.
    logic [15:0] presc_r; // Prescale setting.
    logic halt_r; // Freeze.
    logic run_r; // Run.
    logic auto_r; // Wrap reload mode.
    logic up_r; // Count direction.
    logic en_r; // Block enable.
    logic soft_r; // Soft reset pulse.
    logic irq_r; // Interrupt output register.
    logic [31:0] hrdata_r; // Read data register.
    logic hreadyout_r; // Ready register.
    logic hresp_r; // Response register.

    // Data-phase bookkeeping.
    logic wr_pend_r; // A write data phase is due.
    logic [7:0] wr_addr_r; // Its word address.
    logic [31:0] wr_mask_r; // Its byte lanes.

    // Address phase decode.
    logic addr_ph; // Valid transfer taken this edge.
    logic rd_take; // Read taken.
    logic [7:0] word_a; // Word-aligned address.
    assign addr_ph = hsel && hready && (htrans == bt_pkg::HTRANS_NONSEQ);
    assign rd_take = addr_ph && !hwrite;
    assign word_a = {haddr[7:2], 2'b00};

    // Data phase decode.
    logic [31:0] wdat; // Masked write data.
    logic wr_cnt; // Count write.
    logic wr_pre; // Preload write.
    logic wr_stat; // Status write.
    logic wr_ie; // Enable write.
    logic wr_ctl; // Control write.
    assign wdat = hwdata & wr_mask_r;
    assign wr_cnt = wr_pend_r && (wr_addr_r == bt_pkg::OFF_COUNT);
    assign wr_pre = wr_pend_r && (wr_addr_r == bt_pkg::OFF_PRELOAD);
    assign wr_stat = wr_pend_r && (wr_addr_r == bt_pkg::OFF_STATUS);
    assign wr_ie = wr_pend_r && (wr_addr_r == bt_pkg::OFF_IE);
    assign wr_ctl = wr_pend_r && (wr_addr_r == bt_pkg::OFF_CONTROL);

    // Control actions carried by a control write.
    logic start_rise; // Run bit set from zero.
    logic run_wr; // Run bit written as zero or one.
    logic reload_fire; // Refresh taken.
    logic soft_fire; // Soft reset requested.
    logic stat_clr; // Write-one-clear of status.
    logic ctl_lane_lo; // Low byte of control written.
    assign ctl_lane_lo = wr_ctl && wr_mask_r[0];
    assign run_wr = ctl_lane_lo;
    assign start_rise = ctl_lane_lo && hwdata[bt_pkg::B_RUN] && !run_r;
    assign reload_fire = ctl_lane_lo && hwdata[bt_pkg::B_RELOAD] && run_r;
    assign soft_fire = ctl_lane_lo && hwdata[bt_pkg::B_SOFT];
    assign stat_clr = wr_stat && wr_mask_r[0] && hwdata[bt_pkg::B_EVENT];

    // Counting and terminal detection.
    logic go; // Counter may advance.
    logic step_en; // Counter advances this cycle.
    logic at_lim; // Counter sits at its saturation point.
    logic term; // Terminal event this cycle.
    logic [31:0] step_v; // Stepped count.
    assign go = en_r && run_r && !halt_r;
    assign step_en = go && tk.tick;
    assign at_lim = up_r ? (cnt_r == CMASK) : (cnt_r == 32'h0000_0000);
    assign term = step_en && at_lim;
    assign step_v = up_r ? ((cnt_r + 32'h0000_0001) & CMASK) : ((cnt_r - 32'h0000_0001) & CMASK);

    // Prescaler hookup; a fresh start restarts the divider.
    assign tk.restart = start_rise;
    assign tk.go = go;
    assign tk.presc = presc_r;

    bt_prescaler u_presc (
        .clock (clock),
        .srst (srst),
        .ce (ce),
        .p (tk)
    );

    // Next values.
    logic [31:0] cnt_nxt; // Next count.
    logic stat_nxt; // Next status.
    logic run_nxt; // Next run bit.
    logic [31:0] rd_word; // Read mux output.

    // Register writes beat a refresh, which beats counting.
    assign cnt_nxt = wr_cnt ? ((cnt_r & ~wr_mask_r) | (wdat & CMASK)) :
                     reload_fire ? (pre_r & CMASK) :
                     (term && auto_r) ? (pre_r & CMASK) :
                     (step_en && !at_lim) ? step_v :
                     cnt_r;

    // A new event wins over a clear in the same cycle.
    assign stat_nxt = term ? 1'b1 :
                      start_rise ? 1'b0 :
                      (stat_r && auto_r) ? 1'b0 :
                      stat_clr ? 1'b0 : stat_r;

    // A software write of the run bit wins over the self-clear.
    assign run_nxt = run_wr ? hwdata[bt_pkg::B_RUN] :
                     (term && !auto_r) ? 1'b0 : run_r;

    // Read mux; reserved bits read zero.
    assign rd_word = (word_a == bt_pkg::OFF_COUNT) ? (haddr[1:0] == 2'b00 ? cnt_r : snap_r) :
                     (word_a == bt_pkg::OFF_PRELOAD) ? pre_r :
                     (word_a == bt_pkg::OFF_STATUS) ? {31'h0000_0000, stat_r} :
                     (word_a == bt_pkg::OFF_IE) ? {31'h0000_0000, ie_r} :
                     (word_a == bt_pkg::OFF_CONTROL) ?
                     {presc_r, 8'h00, halt_r, 1'b0, run_r, 1'b0, auto_r, up_r, 1'b0, en_r} :
                     32'h0000_0000;

    // Bus slave: always ready, always OKAY, read data registered at the address edge.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            hrdata_r <= bt_pkg::RST_WORD;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_mask_r <= bt_pkg::RST_WORD;
        end
        else if (ce)
        begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            wr_pend_r <= addr_ph && hwrite;
            wr_addr_r <= word_a;
            wr_mask_r <= lane_mask(hsize, haddr[1:0]);
            if (rd_take)
                hrdata_r <= rd_word;
        end
    end

    // Snapshot taken on any read that starts at the low byte of the count.
    always_ff @(posedge clock)
    begin
        if (srst || soft_r)
            snap_r <= bt_pkg::RST_WORD;
        else if (ce && rd_take && (word_a == bt_pkg::OFF_COUNT) && (haddr[1:0] == 2'b00))
            snap_r <= cnt_r;
    end

    // Counter, preload and status; the soft reset pulse returns them to defaults.
    always_ff @(posedge clock)
    begin
        if (srst || soft_r)
        begin
            cnt_r <= bt_pkg::RST_WORD;
            pre_r <= bt_pkg::RST_WORD;
            stat_r <= 1'b0;
            ie_r <= 1'b0;
        end
        else if (ce)
        begin
            cnt_r <= cnt_nxt;
            stat_r <= stat_nxt;
            if (wr_pre)
                pre_r <= ((pre_r & ~wr_mask_r) | wdat) & CMASK;
            if (wr_ie && wr_mask_r[0])
                ie_r <= hwdata[bt_pkg::B_EVENT];
        end
    end

    // Control word fields.
    always_ff @(posedge clock)
    begin
        if (srst || soft_r)
        begin
            presc_r <= bt_pkg::RST_PRESC;
            halt_r <= 1'b0;
            run_r <= 1'b0;
            auto_r <= 1'b0;
            up_r <= 1'b0;
            en_r <= 1'b0;
        end
        else if (ce)
        begin
            run_r <= run_nxt;
            if (wr_ctl && (wr_mask_r[31:16] != 16'h0000))
                presc_r <= (presc_r & ~wr_mask_r[31:16]) | wdat[31:16];
            if (ctl_lane_lo)
            begin
                halt_r <= hwdata[bt_pkg::B_HALT];
                auto_r <= hwdata[bt_pkg::B_AUTO];
                up_r <= hwdata[bt_pkg::B_UP];
                en_r <= hwdata[bt_pkg::B_ENABLE];
            end
        end
    end

    // Soft reset lasts exactly one cycle and is never stored as a readable bit.
    always_ff @(posedge clock)
    begin
        if (srst || soft_r)
            soft_r <= 1'b0;
        else if (ce)
            soft_r <= soft_fire;
    end

    // Interrupt output, registered so it never glitches.
    always_ff @(posedge clock)
    begin
        if (srst)
            irq_r <= 1'b0;
        else if (ce)
            irq_r <= stat_nxt && ie_r && !soft_r;
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign irq = irq_r;

    // Checks of the timer behaviour.
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_soft_req;
        ce && soft_fire && !soft_r;
    endsequence
    sequence s_soft_done;
        soft_r ##1 (ce [*1]);
    endsequence

    a_bus_ready: assert property (hreadyout && !hresp)
        else $error("slave not ready or not OKAY");
    a_count_cause: assert property ($changed(cnt_r) |->
        $past(step_en || wr_cnt || reload_fire || soft_r))
        else $error("count moved without a cause");
    a_run_selfclr: assert property (ce && term && !auto_r && !run_wr |=> !run_r)
        else $error("run bit not cleared at terminal");
    a_run_autokeep: assert property (ce && term && auto_r && !run_wr && !soft_r |=> run_r)
        else $error("run bit dropped in auto mode");
    a_soft_onecyc: assert property (s_soft_req |=> soft_r ##1 !soft_r)
        else $error("soft reset not a single cycle");
    a_soft_clears: assert property (s_soft_done |-> ##0 (!run_r && !en_r))
        else $error("soft reset left control set");
    a_auto_pulse: assert property (ce && stat_r && auto_r && !term && !soft_r |=> !stat_r)
        else $error("auto mode status not a pulse");
    a_level_hold: assert property (ce && stat_r && !auto_r && !stat_clr && !start_rise
        && !soft_r |=> stat_r)
        else $error("level status lost");
    a_up_saturate: assert property (ce && step_en && up_r && at_lim && !auto_r
        && !wr_cnt && !reload_fire && !soft_r |=> cnt_r == CMASK)
        else $error("up count not saturated");
    a_down_zero: assert property (ce && step_en && !up_r && at_lim && !auto_r
        && !wr_cnt && !reload_fire && !soft_r |=> cnt_r == 32'h0000_0000)
        else $error("down count not saturated at zero");
    a_start_clrstat: assert property (ce && start_rise && !soft_r |=> !stat_r)
        else $error("start did not clear status");
    a_halt_freeze: assert property (ce && halt_r && !wr_cnt && !reload_fire
        && !soft_r |=> $stable(cnt_r))
        else $error("counter moved while frozen");
    a_irq_gate: assert property (ce && !ie_r |=> !irq_r)
        else $error("interrupt without enable");
    a_upper_zero: assert property ((cnt_r & ~CMASK) == 32'h0000_0000
        && (pre_r & ~CMASK) == 32'h0000_0000)
        else $error("unimplemented count bits set");

endmodule : bt_timer

// *** pkg/bt_pkg.sv ***
// Constants shared by the basic timer control block.
package bt_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_COUNT = 8'h00;
    localparam logic [7:0] OFF_PRELOAD = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_IE = 8'h0C;
    localparam logic [7:0] OFF_CONTROL = 8'h10;

    // Control, status and interrupt enable field positions.
    localparam int B_ENABLE = 0;
    localparam int B_UP = 2;
    localparam int B_AUTO = 3;
    localparam int B_SOFT = 4;
    localparam int B_RUN = 5;
    localparam int B_RELOAD = 6;
    localparam int B_HALT = 7;
    localparam int B_PRESC_LO = 16;
    localparam int B_EVENT = 0;

    // Counter width of the default variant, 16 or 32.
    localparam int CNT_W_DEF = 16;

    // Values after reset.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_PRESC = 16'h0000;

    // Bus encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_BYTE = 3'b000;
    localparam logic [2:0] HSIZE_HALF = 3'b001;

endpackage : bt_pkg

// *** pkg/bt_tick_if.sv ***
// Link between timer control and its clock-enable prescaler.
`timescale 1ns/1ps
interface bt_tick_if;
    logic restart; // Restart the divider from zero.
    logic go; // Divider may run.
    logic [15:0] presc; // Clocks per pulse minus one.
    logic tick; // One-cycle clock-enable pulse.

    modport ctl (output restart, output go, output presc, input tick);
    modport div (input restart, input go, input presc, output tick);
endinterface : bt_tick_if

// *** testbench/basic_timer_control_test.sv ***
// Self-checking bench for the basic timer: AHB-Lite register access and counting.
`timescale 1ns/1ps
module basic_timer_control_test;
    logic clock = 1'b0; // System clock, 40 ns period.
    logic srst = 1'b1; // Synchronous reset, held at start.
    logic ce = 1'b1; // Clock enable, kept on.
    logic hsel = 1'b0; // Slave select.
    logic [7:0] haddr = 8'h00; // Byte address.
    logic [1:0] htrans = 2'b00; // Transfer type.
    logic hwrite = 1'b0; // Write strobe.
    logic [2:0] hsize = 3'b010; // Transfer size.
    logic [31:0] hwdata = 32'h0000_0000; // Write data.
    logic [31:0] hrdata; // Read data.
    logic hreadyout; // Slave ready, fed back as hready.
    logic hresp; // Response.
    logic irq; // Interrupt.
    int err_total = 0; // Mismatches seen.
    int n_tests = 0; // Comparisons made.
    logic [15:0] lfsr_r = 16'd11800; // Random source state.
    logic [31:0] a, b, c; // Scratch read values.
    int t0, t1, p; // Scratch cycle counts.

    // The clock toggles every half period.
    always #20 clock = ~clock;

    bt_timer #(.CNT_W(16)) DUT (.clock(clock), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

    // Galois shift register step; the seed is fixed so runs repeat.
    function automatic logic [15:0] rnd();
        lfsr_r = {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? 16'hB400 : 16'h0000);
        return lfsr_r;
    endfunction : rnd

    // The narrow variant keeps only the low half of count and preload.
    function automatic logic [31:0] narrow(input logic [31:0] v);
        return {16'h0000, v[15:0]};
    endfunction : narrow

    // Control readback: reserved, soft reset and reload bits read zero.
    function automatic logic [31:0] ctl_view(input logic [31:0] v);
        return v & 32'hFFFF_00AD;
    endfunction : ctl_view

    // Compare and count; a mismatch is reported at once.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // One single AHB transfer, entered and left just after a rising edge.
    task automatic bus(input logic w, input logic [7:0] ad, input logic [2:0] sz,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= ad;
        htrans <= bt_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= sz;
        // The address phase stands until ready is sampled high; only the watchdog ends a stall.
        do
        begin
            @(posedge clock);
        end
        while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        // The data phase ends at the next edge that samples ready.
        do
        begin
            @(posedge clock);
        end
        while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("response", 32'h0000_0000, {31'h0, hresp});
        chk("ready", 32'h0000_0001, {31'h0, hreadyout});
    endtask : bus

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, ad, 3'b010, wd, dummy);
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [31:0] v);
        bus(1'b0, ad, 3'b010, 32'h0000_0000, v);
    endtask : rd

    // Starts a down count and returns the clocks until the interrupt rises.
    task automatic meas(input logic [15:0] ps, input logic [15:0] n, output int cyc);
        wr(bt_pkg::OFF_COUNT, {16'h0000, n});
        // The prescale only changes here, while the timer is stopped, so no pulse is irregular.
        wr(bt_pkg::OFF_CONTROL, {ps, 16'h0021});
        cyc = 0;
        while (irq !== 1'b1 && cyc < 2000)
        begin
            @(posedge clock);
            cyc++;
        end
        wr(bt_pkg::OFF_STATUS, 32'h0000_0001);
    endtask : meas

    // Single place where the run ends.
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // Watchdog: the tests need a few thousand clocks at most.
    initial
    begin
        repeat (30000) @(posedge clock);
        err_total++;
        wrap_up();
    end

    // Main sequence.
    initial
    begin
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 6; i++)
        begin
            rd(8'(4 * i), a);
            chk("reset value", 32'h0000_0000, a);
        end
        for (int i = 0; i < 4; i++)
        begin
            b = {rnd(), rnd()};
            wr(8'(4 * (i % 2)), b);
            rd(8'(4 * (i % 2)), a);
            chk("narrow word", narrow(b), a);
        end
        b = {rnd(), 16'hFF5E};
        wr(bt_pkg::OFF_CONTROL, b);
        rd(bt_pkg::OFF_CONTROL, a);
        chk("control view", ctl_view(b), a);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0000);
        wr(bt_pkg::OFF_IE, 32'h0000_0001);
        // Down count to zero in done mode.
        wr(bt_pkg::OFF_COUNT, 32'h0000_0002);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0021);
        repeat (12) @(posedge clock);
        rd(bt_pkg::OFF_STATUS, a);
        chk("status level", 32'h0000_0001, a);
        chk("irq level", 32'h0000_0001, {31'h0, irq});
        rd(bt_pkg::OFF_CONTROL, a);
        chk("run cleared", 32'h0000_0001, a);
        rd(bt_pkg::OFF_COUNT, a);
        chk("down saturate", 32'h0000_0000, a);
        wr(bt_pkg::OFF_IE, 32'h0000_0000);
        // The registered output is built from the old enable at the write edge, so wait two edges.
        repeat (2) @(posedge clock);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        wr(bt_pkg::OFF_IE, 32'h0000_0001);
        // Restart clears the pending status.
        wr(bt_pkg::OFF_COUNT, 32'h0000_0050);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0021);
        rd(bt_pkg::OFF_STATUS, a);
        chk("start clears", 32'h0000_0000, a);
        // Halt, resume, reload, gate and stop on a running down count.
        wr(bt_pkg::OFF_PRELOAD, 32'h0000_00C8);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_00A1);
        rd(bt_pkg::OFF_COUNT, a);
        repeat (10) @(posedge clock);
        rd(bt_pkg::OFF_COUNT, b);
        chk("halt holds", a, b);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0021);
        repeat (10) @(posedge clock);
        rd(bt_pkg::OFF_COUNT, c);
        chk("resume counts", 32'h0000_0001, {31'h0, c < b});
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0061);
        rd(bt_pkg::OFF_COUNT, a);
        chk("reload", 32'h0000_0001, {31'h0, a > 32'd150 && a <= 32'd200});
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0020);
        rd(bt_pkg::OFF_COUNT, a);
        repeat (10) @(posedge clock);
        rd(bt_pkg::OFF_COUNT, b);
        chk("disabled holds", a, b);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0001);
        rd(bt_pkg::OFF_COUNT, a);
        repeat (10) @(posedge clock);
        rd(bt_pkg::OFF_COUNT, b);
        chk("stopped holds", a, b);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0041);
        rd(bt_pkg::OFF_COUNT, b);
        chk("reload ignored", a, b);
        // Prescale: one more count costs setting plus one clocks.
        for (int i = 0; i < 4; i++)
        begin
            p = (i == 0) ? 0 : int'(rnd() % 16'd4);
            meas(16'(p), 16'h0004, t0);
            meas(16'(p), 16'h0005, t1);
            chk("prescale step", 32'(p + 1), 32'(t1 - t0));
        end
        // Up count saturates at all ones.
        wr(bt_pkg::OFF_COUNT, 32'h0000_FFFE);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0025);
        repeat (10) @(posedge clock);
        rd(bt_pkg::OFF_COUNT, a);
        chk("up saturate", 32'h0000_FFFF, a);
        rd(bt_pkg::OFF_STATUS, a);
        chk("up event", 32'h0000_0001, a);
        wr(bt_pkg::OFF_STATUS, 32'h0000_0001);
        // Auto mode: one-cycle pulses, period preload plus one ticks.
        wr(bt_pkg::OFF_PRELOAD, 32'h0000_0003);
        wr(bt_pkg::OFF_COUNT, 32'h0000_0001);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0029);
        t0 = 0;
        while (irq !== 1'b1 && t0 < 50)
        begin
            @(posedge clock);
            t0++;
        end
        @(posedge clock);
        chk("pulse width", 32'h0000_0000, {31'h0, irq});
        t1 = 1;
        while (irq !== 1'b1 && t1 < 50)
        begin
            @(posedge clock);
            t1++;
        end
        chk("auto period", 32'd4, 32'(t1));
        rd(bt_pkg::OFF_CONTROL, a);
        chk("run stays", 32'h0000_0029, a);
        // Byte reads see one snapshot of the count.
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0001);
        wr(bt_pkg::OFF_COUNT, 32'h0000_0110);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0021);
        bus(1'b0, 8'h00, bt_pkg::HSIZE_BYTE, 32'h0000_0000, a);
        repeat (40) @(posedge clock);
        bus(1'b0, 8'h01, bt_pkg::HSIZE_BYTE, 32'h0000_0000, b);
        chk("snapshot byte", 32'h0000_0001, {24'h0, b[15:8]});
        // Soft reset returns preload and control to defaults.
        wr(bt_pkg::OFF_PRELOAD, 32'h0000_1234);
        wr(bt_pkg::OFF_CONTROL, 32'h0000_0010);
        repeat (3) @(posedge clock);
        rd(bt_pkg::OFF_PRELOAD, a);
        chk("soft preload", 32'h0000_0000, a);
        rd(bt_pkg::OFF_CONTROL, a);
        chk("soft control", 32'h0000_0000, a);
        wrap_up();
    end
endmodule : basic_timer_control_test
